// ==== cvs_status_block.sv ====
/*
  status flags, combined interrupt and result hand-off of a dual converter.
  assumes: bus strobes, converter events and straps come from logic on mclk;
  the sleep level comes from the power controller on another clock and is
  synchronised here. filter and current-control registers live elsewhere;
  only their write strobes arrive here.
*/
`timescale 1ns/1ps
`include "cvs_defs.svh"

module cvs_status_block (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // register access from the core
  input  wire cvs_pkg::cvs_bus_req_t bus_req,
  output logic [15:0]            bus_rdata,
  // write strobes of control registers held elsewhere
  input  wire logic              filter_wr,
  input  wire logic              cur_ctrl_wr,
  // converter side
  input  wire cvs_pkg::cvs_conv_t cur_conv,
  input  wire cvs_pkg::cvs_conv_t vt_conv,
  input  wire logic              cal_done,
  input  wire logic              cur_chan_en,
  input  wire logic              volt_chan_en,
  input  wire logic              temp_chan_en,
  // core power state, asynchronous
  input  wire logic              core_asleep,
  // interrupt toward the core
  output logic                   converter_irq
);

  //////////////////////////////////////////////////////////////////////////
  cvs_pkg::cvs_state_t st_reg;
  cvs_pkg::cvs_state_t st_next;
  logic                sleep_meta_reg;
  logic                sleep_sync_reg;

  logic rd_cur;
  logic rd_vt;
  logic wr_mode;
  logic wr_cfg;
  logic reconfig;
  logic clr_all_rdy;
  logic ready_any;
  logic load_cur;
  logic load_vt;
  logic [15:0] cur_val;
  logic [15:0] vt_val;
  logic [15:0] cur_abs;

  // two-stage synchroniser on the sleep level; only stage two is read
  always_ff @(posedge mclk) begin
    if (rst) begin
      sleep_meta_reg <= 1'b0;
      sleep_sync_reg <= 1'b0;
    end else begin
      sleep_meta_reg <= core_asleep;
      sleep_sync_reg <= sleep_meta_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // access decode
  assign rd_cur   = bus_req.rd && (bus_req.addr == `CVS_ADDR_CUR_RESULT);
  assign rd_vt    = bus_req.rd && (bus_req.addr == `CVS_ADDR_VT_RESULT);
  assign wr_mode  = bus_req.wr && (bus_req.addr == `CVS_ADDR_MODE);
  assign wr_cfg   = bus_req.wr && (bus_req.addr == `CVS_ADDR_CONFIG);
  // mode, config, filter and current-control writes count as reconfiguring the subsystem
  assign reconfig = wr_mode || wr_cfg || filter_wr || cur_ctrl_wr;

  // ready-flag clearing reads
  assign clr_all_rdy = rd_cur || (rd_vt && !cur_chan_en);

  // loads held off while any ready flag stands, unless the core sleeps
  assign ready_any = |st_reg.status[`CVS_BIT_TEMP_RDY:`CVS_BIT_CUR_RDY];
  assign load_cur  = cur_conv.valid && (!ready_any || sleep_sync_reg);
  assign load_vt   = vt_conv.valid && (!ready_any || sleep_sync_reg);

  // clamp out-of-range results to full scale
  assign cur_val = cur_conv.over  ? `CVS_POS_FULL_SCALE :
                   cur_conv.under ? `CVS_NEG_FULL_SCALE : cur_conv.data;
  assign vt_val  = vt_conv.over   ? `CVS_POS_FULL_SCALE :
                   vt_conv.under  ? `CVS_NEG_FULL_SCALE : vt_conv.data;

  // absolute value of the clamped current result, saturates at 0x8000
  assign cur_abs = cur_val[15] ? 16'((~cur_val) + 16'h0001) : cur_val;

  //////////////////////////////////////////////////////////////////////////
  // next-state: clears first, then sets, so a coinciding event wins
  always_comb begin
    st_next = st_reg;

    // software-writable registers
    if (bus_req.wr && bus_req.addr == `CVS_ADDR_IRQ_MASK) begin
      st_next.irq_mask = bus_req.wdata[7:0];
    end
    if (wr_mode) begin
      st_next.mode = bus_req.wdata[7:0];
    end
    if (wr_cfg) begin
      st_next.config_bits = bus_req.wdata[7:0];
    end
    if (bus_req.wr && bus_req.addr == `CVS_ADDR_THRESHOLD) begin
      st_next.threshold = bus_req.wdata;
    end

    // clears by read or reconfiguration
    if (wr_mode || filter_wr || cur_ctrl_wr) begin
      st_next.status[`CVS_BIT_CAL_DONE] = 1'b0;
    end
    if (reconfig) begin
      st_next.status[`CVS_BIT_CMP] = 1'b0;
    end
    if (clr_all_rdy) begin
      st_next.status[`CVS_BIT_CUR_RDY]  = 1'b0;
      st_next.status[`CVS_BIT_VOLT_RDY] = 1'b0;
      st_next.status[`CVS_BIT_TEMP_RDY] = 1'b0;
    end
    if (rd_vt) begin
      st_next.status[`CVS_BIT_VOLT_RDY] = 1'b0;
      st_next.status[`CVS_BIT_TEMP_RDY] = 1'b0;
    end
    if (rd_cur) begin
      st_next.status[`CVS_BIT_CONT] = 1'b0;
    end

    // calibration end sets the done flag and enabled ready flags
    if (cal_done) begin
      st_next.status[`CVS_BIT_CAL_DONE] = 1'b1;
      if (cur_chan_en) begin
        st_next.status[`CVS_BIT_CUR_RDY] = 1'b1;
      end
      if (volt_chan_en) begin
        st_next.status[`CVS_BIT_VOLT_RDY] = 1'b1;
      end
      if (temp_chan_en) begin
        st_next.status[`CVS_BIT_TEMP_RDY] = 1'b1;
      end
    end

    // every current conversion, settled or not, may flag continuous
    if (cur_conv.valid && st_reg.mode[`CVS_MODE_BIT_CONT]) begin
      st_next.status[`CVS_BIT_CONT] = 1'b1;
    end

    // comparator on the clamped current result
    if (cur_conv.valid && st_reg.config_bits[`CVS_CFG_BIT_CMP_EN]
        && (cur_abs > st_reg.threshold)) begin
      st_next.status[`CVS_BIT_CMP] = 1'b1;
    end

    // current result load; the load beats a same-cycle clearing read
    if (load_cur) begin
      st_next.cur_result = cur_val;
      st_next.status[`CVS_BIT_CUR_ERR] = cur_conv.over || cur_conv.under;
      if (cur_chan_en) begin
        st_next.status[`CVS_BIT_CUR_RDY] = 1'b1;
      end
    end

    // voltage/temperature result load
    if (load_vt) begin
      st_next.vt_result = vt_val;
      st_next.status[`CVS_BIT_VT_ERR] = vt_conv.over || vt_conv.under;
      if (volt_chan_en) begin
        st_next.status[`CVS_BIT_VOLT_RDY] = 1'b1;
      end
      if (temp_chan_en) begin
        st_next.status[`CVS_BIT_TEMP_RDY] = 1'b1;
      end
    end

    // reserved bits are never set
    st_next.status[14]   = 1'b0;
    st_next.status[11:6] = 6'h00;
    st_next.status[3]    = 1'b0;

    // read data registered: answer one cycle after the read strobe
    case (bus_req.addr)
      `CVS_ADDR_STATUS:     st_next.rdata = st_reg.status;
      `CVS_ADDR_IRQ_MASK:   st_next.rdata = {8'h00, st_reg.irq_mask};
      `CVS_ADDR_MODE:       st_next.rdata = {8'h00, st_reg.mode};
      `CVS_ADDR_CONFIG:     st_next.rdata = {8'h00, st_reg.config_bits};
      `CVS_ADDR_THRESHOLD:  st_next.rdata = st_reg.threshold;
      `CVS_ADDR_CUR_RESULT: st_next.rdata = st_reg.cur_result;
      `CVS_ADDR_VT_RESULT:  st_next.rdata = st_reg.vt_result;
      default:              st_next.rdata = 16'h0000;
    endcase
    if (!bus_req.rd) begin
      st_next.rdata = 16'h0000;
    end

    // only the masked lower byte reaches the interrupt
    st_next.irq = |(st_next.status[7:0] & st_next.irq_mask);
  end

  //////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg.status      <= `CVS_STATUS_RESET;
      st_reg.irq_mask    <= `CVS_MASK_RESET;
      st_reg.mode        <= `CVS_MODE_RESET;
      st_reg.config_bits <= `CVS_CFG_RESET;
      st_reg.threshold   <= `CVS_THRESH_RESET;
      st_reg.cur_result  <= `CVS_RESULT_RESET;
      st_reg.vt_result   <= `CVS_RESULT_RESET;
      st_reg.rdata       <= 16'h0000;
      st_reg.irq         <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus_rdata     = st_reg.rdata;
  assign converter_irq = st_reg.irq;

endmodule // cvs_status_block

// ==== cvs_defs.svh ====
/*
  constants for the converter status and result hand-off block:
  register addresses, status bit positions, reset values, full-scale codes.
  assumes inclusion by bare name from the design file, the checker and the bench.
*/
`ifndef CVS_DEFS_SVH
`define CVS_DEFS_SVH

`define CVS_ADDR_STATUS      32'hFFFF0500
`define CVS_ADDR_IRQ_MASK    32'hFFFF0504
`define CVS_ADDR_MODE        32'hFFFF0508
`define CVS_ADDR_FILTER      32'hFFFF050C
`define CVS_ADDR_CUR_CTRL    32'hFFFF0510
`define CVS_ADDR_CONFIG      32'hFFFF0514
`define CVS_ADDR_CUR_RESULT  32'hFFFF0518
`define CVS_ADDR_VT_RESULT   32'hFFFF051C
`define CVS_ADDR_THRESHOLD   32'hFFFF0520

`define CVS_BIT_CAL_DONE     15
`define CVS_BIT_VT_ERR       13
`define CVS_BIT_CUR_ERR      12
`define CVS_BIT_CONT         5
`define CVS_BIT_CMP          4
`define CVS_BIT_TEMP_RDY     2
`define CVS_BIT_VOLT_RDY     1
`define CVS_BIT_CUR_RDY      0
`define CVS_MODE_BIT_CONT    5
`define CVS_CFG_BIT_CMP_EN   0

`define CVS_STATUS_RESET     16'h0000
`define CVS_MASK_RESET       8'h00
`define CVS_MODE_RESET       8'h00
`define CVS_CFG_RESET        8'h00
`define CVS_RESULT_RESET     16'h0000
`define CVS_THRESH_RESET     16'h0000
`define CVS_POS_FULL_SCALE   16'h7FFF
`define CVS_NEG_FULL_SCALE   16'h8000

`endif

// ==== cvs_pkg.sv ====
/*
  types for the converter status block: bus request, converter events,
  and the single packed state record of the top module.
  assumes cvs_defs.svh is on the include path.
*/
package cvs_pkg;

  // one register access from the core, valid for a single cycle
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [31:0] addr;
    logic [15:0] wdata;
  } cvs_bus_req_t;

  // one finished conversion from a converter, with its range verdict
  typedef struct packed {
    logic        valid;
    logic [15:0] data;
    logic        over;
    logic        under;
  } cvs_conv_t;

  // state of the block apart from the sleep synchroniser
  typedef struct packed {
    logic [15:0] status;
    logic [7:0]  irq_mask;
    logic [7:0]  mode;
    logic [7:0]  config_bits;
    logic [15:0] threshold;
    logic [15:0] cur_result;
    logic [15:0] vt_result;
    logic [15:0] rdata;
    logic        irq;
  } cvs_state_t;

endpackage

// ==== cvs_status_block_sva.sv ====
/* port checker for the converter status block.
   assumes cvs_defs.svh on the include path; bound at the foot. */
`timescale 1ns/1ps
`include "cvs_defs.svh"
module cvs_status_sva (
  // clock and reset
  input wire logic                  mclk,
  input wire logic                  rst,
  // core bus and control strobes
  input wire cvs_pkg::cvs_bus_req_t bus_req,
  input wire logic [15:0]           bus_rdata,
  input wire logic                  filter_wr,
  input wire logic                  cur_ctrl_wr,
  // converter side and interrupt
  input wire cvs_pkg::cvs_conv_t    cur_conv,
  input wire cvs_pkg::cvs_conv_t    vt_conv,
  input wire logic                  cal_done,
  input wire logic                  cur_chan_en,
  input wire logic                  volt_chan_en,
  input wire logic                  temp_chan_en,
  input wire logic                  converter_irq
);
  logic st_rd, cur_rd, quiet, calm, mask_seen_reg;
  // decoded strobes; quiet means no flag can be set this cycle
  assign st_rd  = bus_req.rd && bus_req.addr == `CVS_ADDR_STATUS;
  assign cur_rd = bus_req.rd && bus_req.addr == `CVS_ADDR_CUR_RESULT;
  assign quiet  = !cur_conv.valid && !vt_conv.valid && !cal_done;
  assign calm   = !bus_req.wr && !filter_wr && !cur_ctrl_wr;
  // mask is zero until written, so no interrupt can exist before that
  always_ff @(posedge mclk) begin
    mask_seen_reg <= !rst && (mask_seen_reg
                              || (bus_req.wr && bus_req.addr == `CVS_ADDR_IRQ_MASK));
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  //////////////////////////////////////////////////////////////////////////////
  property p_reset; $fell(rst) |-> bus_rdata == 16'h0000 && !converter_irq; endproperty
  a_reset: assert property (p_reset) else $error("outputs not clear after reset");
  property p_idle; !bus_req.rd |=> bus_rdata == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("read data without a read");
  property p_rsvd;
    st_rd |=> bus_rdata[14] == 1'b0 && bus_rdata[11:6] == 6'h00 && !bus_rdata[3];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved status bit set");
  property p_rdy_clr;
    cur_rd && quiet ##1 quiet ##1 st_rd && quiet |=> bus_rdata[2:0] == 3'h0 && !bus_rdata[5];
  endproperty
  a_rdy_clr: assert property (p_rdy_clr) else $error("ready flags kept after read");
  property p_cal_set;
    cal_done && cur_chan_en && volt_chan_en && temp_chan_en ##1 calm && !bus_req.rd ##1 st_rd && calm
      |=> bus_rdata[15] && bus_rdata[2:0] == 3'h7;
  endproperty
  a_cal_set: assert property (p_cal_set) else $error("calibration flags missing");
  property p_cal_clr;
    (filter_wr || cur_ctrl_wr) && !cal_done ##1 !cal_done ##1 st_rd && !cal_done
      |=> !bus_rdata[15];
  endproperty
  a_cal_clr: assert property (p_cal_clr) else $error("calibration flag kept");
  property p_cmp_clr;
    (cur_ctrl_wr || (bus_req.wr && bus_req.addr == `CVS_ADDR_CONFIG)) && quiet
      ##1 quiet ##1 st_rd && quiet |=> !bus_rdata[4];
  endproperty
  a_cmp_clr: assert property (p_cmp_clr) else $error("comparator flag kept");
  property p_no_irq; !mask_seen_reg |-> !converter_irq; endproperty
  a_no_irq: assert property (p_no_irq) else $error("interrupt with all masked");
  // main scenarios reached
  c_irq: cover property ($rose(converter_irq));
  c_cal: cover property (cal_done ##2 st_rd);
  c_clr: cover property (cur_rd ##2 st_rd);
endmodule // cvs_status_sva
bind cvs_status_block cvs_status_sva chk (.mclk, .rst, .bus_req, .bus_rdata, .filter_wr, .cur_ctrl_wr,
  .cur_conv, .vt_conv, .cal_done, .cur_chan_en, .volt_chan_en, .temp_chan_en, .converter_irq);

// ==== cvs_core_model.sv ====
/* processor core model issuing one-cycle register reads and writes.
   assumes the block samples the request on rising mclk. */
`timescale 1ns/1ps
module cvs_core_model (
  // clock
  input wire logic              mclk,
  // register bus
  output cvs_pkg::cvs_bus_req_t bus_req,
  input wire logic [15:0]       bus_rdata
);
  initial bus_req = '0;
  // released fields show inverted values so stale data is never trusted
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge mclk) #1 bus_req = '{1'b0, 1'b1, a, d};
    @(posedge mclk) #1 bus_req = '{1'b0, 1'b0, ~a, ~d};
  endtask
  // read data stands only the cycle after the strobe, taken right then
  task automatic rd(input logic [31:0] a, output logic [15:0] d);
    @(posedge mclk) #1 bus_req = '{1'b1, 1'b0, a, 16'h0000};
    @(posedge mclk) #1 bus_req = '{1'b0, 1'b0, ~a, 16'hFFFF};
    d = bus_rdata;
  endtask
endmodule // cvs_core_model

// ==== tb_cvs_status_block.sv ====
/* self-checking bench for the converter status block.
   assumes the core model on the bus; converter events driven here. */
`timescale 1ns/1ps
`include "cvs_defs.svh"
module tb_cvs_status_block;
  logic                  mclk, rst, filter_wr, cur_ctrl_wr, cal_done, core_asleep;
  logic                  cur_chan_en, volt_chan_en, temp_chan_en, converter_irq;
  logic [15:0]           bus_rdata, d;
  cvs_pkg::cvs_bus_req_t bus_req;
  cvs_pkg::cvs_conv_t    cur_conv, vt_conv;
  int                    n_mismatch, n_checks;
  cvs_status_block uut (.mclk, .rst, .bus_req, .bus_rdata, .filter_wr, .cur_ctrl_wr, .cur_conv,
    .vt_conv, .cal_done, .cur_chan_en, .volt_chan_en, .temp_chan_en, .core_asleep, .converter_irq);
  cvs_core_model core (.mclk, .bus_req, .bus_rdata);
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [31:0] a, input logic [15:0] e);
    core.rd(a, d);
    chk(d, e);
  endtask
  task automatic st(input logic [15:0] e);
    rdc(`CVS_ADDR_STATUS, e);
  endtask
  task automatic pulse(ref logic s);
    @(posedge mclk) #1 s = 1'b1;
    @(posedge mclk) #1 s = 1'b0;
  endtask
  // one conversion pulse; ch 1 is volt/temp
  task automatic conv(input bit ch, input logic [15:0] v, input logic ov, input logic un);
    @(posedge mclk) #1;
    if (ch) vt_conv = '{1'b1, v, ov, un};
    else cur_conv = '{1'b1, v, ov, un};
    @(posedge mclk) #1;
    cur_conv.valid = 1'b0;
    vt_conv.valid = 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    st(16'h0000);
    core.wr(`CVS_ADDR_STATUS, 16'hFFFF);
    st(16'h0000);
    rdc(`CVS_ADDR_IRQ_MASK, 16'h0000);
    rdc(32'hFFFF0524, 16'h0000);
  endtask
  task automatic t_cal();
    pulse(cal_done);
    st(16'h8007);
    core.wr(`CVS_ADDR_IRQ_MASK, 16'h0001);
    @(posedge mclk) #1;
    chk({15'h0000, converter_irq}, 16'h0001);
    pulse(filter_wr);
    st(16'h0007);
    rdc(`CVS_ADDR_VT_RESULT, 16'h0000);
    st(16'h0001);
    rdc(`CVS_ADDR_CUR_RESULT, 16'h0000);
    st(16'h0000);
    chk({15'h0000, converter_irq}, 16'h0000);
  endtask
  // the held-off second conversion must not replace the clamped one
  task automatic t_cur();
    core.wr(`CVS_ADDR_MODE, 16'h0020);
    core.wr(`CVS_ADDR_CONFIG, 16'h0001);
    core.wr(`CVS_ADDR_THRESHOLD, 16'h0100);
    rdc(`CVS_ADDR_MODE, 16'h0020);
    rdc(`CVS_ADDR_CONFIG, 16'h0001);
    rdc(`CVS_ADDR_THRESHOLD, 16'h0100);
    conv(0, 16'h1234, 1'b1, 1'b0);
    st(16'h1031);
    conv(0, 16'h0005, 1'b0, 1'b0);
    rdc(`CVS_ADDR_CUR_RESULT, 16'h7FFF);
    st(16'h1010);
    conv(0, 16'h0005, 1'b0, 1'b0);
    st(16'h0031);
    rdc(`CVS_ADDR_CUR_RESULT, 16'h0005);
    pulse(cur_ctrl_wr);
    st(16'h0000);
  endtask
  // mask keeps the ready bits but not the continuous bit
  task automatic t_vt();
    cur_chan_en = 1'b0;
    temp_chan_en = 1'b0;
    conv(1, 16'h0042, 1'b0, 1'b1);
    st(16'h2002);
    rdc(`CVS_ADDR_VT_RESULT, 16'h8000);
    core.wr(`CVS_ADDR_IRQ_MASK, 16'h001F);
    st(16'h2000);
    chk({15'h0000, converter_irq}, 16'h0000);
    conv(1, 16'h0042, 1'b0, 1'b0);
    st(16'h0002);
    chk({15'h0000, converter_irq}, 16'h0001);
  endtask
  // the sleep level is synchronised, so give it time before converting
  task automatic t_sleep();
    cur_chan_en = 1'b1;
    core_asleep = 1'b1;
    repeat (3) @(posedge mclk);
    conv(0, 16'h0011, 1'b0, 1'b0);
    conv(0, 16'h0022, 1'b0, 1'b0);
    // read and load land on the same edge: old data read, load wins
    fork
      rdc(`CVS_ADDR_CUR_RESULT, 16'h0022);
      conv(0, 16'h0033, 1'b0, 1'b0);
    join
    st(16'h0021);
    rdc(`CVS_ADDR_CUR_RESULT, 16'h0033);
  endtask
  task automatic conclude();
    if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    {rst, filter_wr, cur_ctrl_wr, cal_done, core_asleep} = 5'h10;
    {cur_chan_en, volt_chan_en, temp_chan_en} = 3'h7;
    cur_conv = '0;
    vt_conv = '0;
    n_mismatch = 0;
    n_checks = 0;
    repeat (6) @(posedge mclk);
    #1 rst = 1'b0;
    t_reset();
    t_cal();
    t_cur();
    t_vt();
    t_sleep();
    conclude();
  end
  // watchdog, far beyond the hundred or so cycles the tests need
  initial begin
    #100000;
    n_mismatch++;
    conclude();
  end
endmodule // tb_cvs_status_block
